// file: rtl/rpt_regs.svh
`ifndef RPT_REGS_SVH
`define RPT_REGS_SVH
`define RPT_SAMPLE_DELAY_NS  1500
`define RPT_CLK_PERIOD_NS    40
`define RPT_SAMPLE_CYCLES    (`RPT_SAMPLE_DELAY_NS / `RPT_CLK_PERIOD_NS)
`define RPT_CFG_CYCLES       16
`define RPT_ADDR_CTRL        12'h000
`define RPT_ADDR_STATUS      12'h004
`define RPT_ADDR_STRAP       12'h008
`define RPT_CTRL_RESET       32'h0000_0000
`define RPT_ST_CONFIGURED    0
`define RPT_ST_TEST_MODE     1
`define RPT_ST_PARKED        2
`define RPT_ST_MFG_TEST      3
`define RPT_ST_PHASE_LSB     4
`define RPT_RESP_OKAY        2'b00
`define RPT_RESP_SLVERR      2'b10
`endif

// file: rtl/rpt_pkg.sv
package rpt_pkg;
  typedef enum logic [2:0] {
    RPT_HELD    = 3'b000,
    RPT_WAIT    = 3'b001,
    RPT_CONFIG  = 3'b010,
    RPT_RUN     = 3'b011,
    RPT_PARKING = 3'b100,
    RPT_PARKED  = 3'b101
  } rpt_state_t;
endpackage

// file: rtl/rpt_sync2.sv
module rpt_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = i_rst ? i_rst_val : i_async;
    sync_next = i_rst ? i_rst_val : meta_reg;
  end

  always_ff @(posedge i_clk) begin
    meta_reg <= meta_next;
    o_sync   <= sync_next;
  end
endmodule

// file: rtl/rpt_top.sv
`include "rpt_regs.svh"

module rpt_top import rpt_pkg::*; #(
  parameter int TP_WIDTH   = 8,
  parameter int CFG_CYCLES = `RPT_CFG_CYCLES
) (
  // Clock and reset
  input  wire logic                I_MCLK,
  input  wire logic                I_RESET,
  // Power management pins
  input  wire logic                I_POWER_ON_RESET_N,
  input  wire logic                I_FAST_PARK_N,
  input  wire logic                I_MANUFACTURING_TEST_STRAP,
  input  wire logic                I_TEST_PORT_RESET_N,
  // Test point pins
  input  wire logic [TP_WIDTH-1:0] I_TEST_POINT_PINS,
  output logic      [TP_WIDTH-1:0] O_TEST_POINT_PINS,
  output logic      [TP_WIDTH-1:0] O_TEST_POINT_PINS_OE_N,
  // Status to the rest of the device
  output logic                     O_CONFIG_START,
  output logic                     O_CONFIGURED,
  output logic                     O_TEST_MODE,
  output logic                     O_MIRROR_PARK,
  output logic                     O_MIRROR_FAST,
  // AXI4-Lite slave
  input  wire logic [11:0]         I_AWADDR,
  input  wire logic                I_AWVALID,
  output logic                     O_AWREADY,
  input  wire logic [31:0]         I_WDATA,
  input  wire logic [3:0]          I_WSTRB,
  input  wire logic                I_WVALID,
  output logic                     O_WREADY,
  output logic [1:0]               O_BRESP,
  output logic                     O_BVALID,
  input  wire logic                I_BREADY,
  input  wire logic [11:0]         I_ARADDR,
  input  wire logic                I_ARVALID,
  output logic                     O_ARREADY,
  output logic [31:0]              O_RDATA,
  output logic [1:0]               O_RRESP,
  output logic                     O_RVALID,
  input  wire logic                I_RREADY
);
  localparam int SAMPLE_CYCLES = `RPT_SAMPLE_CYCLES;

  // Pin synchronisers
  logic [3:0] pin_sync;
  logic [TP_WIDTH-1:0] tp_sync;
  rpt_sync2 #(.WIDTH(4)) u_sync_ctl (
    .i_clk     (I_MCLK),
    .i_rst     (I_RESET),
    .i_async   ({I_TEST_PORT_RESET_N, I_MANUFACTURING_TEST_STRAP, I_FAST_PARK_N, I_POWER_ON_RESET_N}),
    .i_rst_val (4'h2),
    .o_sync    (pin_sync)
  );
  rpt_sync2 #(.WIDTH(TP_WIDTH)) u_sync_tp (
    .i_clk     (I_MCLK),
    .i_rst     (I_RESET),
    .i_async   (I_TEST_POINT_PINS),
    .i_rst_val ('0),
    .o_sync    (tp_sync)
  );
  logic por_n;
  logic park_n;
  logic mfg_strap;
  assign por_n     = pin_sync[0];
  assign park_n    = pin_sync[1];
  assign mfg_strap = pin_sync[2];

  // Sequencer
  rpt_state_t          state_reg, state_next;
  logic [15:0]         cnt_reg, cnt_next;
  logic [TP_WIDTH-1:0] mode_reg, mode_next;
  logic                por_d_reg;
  logic                start_next, cfg_next, test_next, park_next, fast_next;
  logic [TP_WIDTH-1:0] oe_n_next, tp_out_next;
  logic                cfg_done;
  logic [31:0]         ctrl_reg, ctrl_next;

  assign cfg_done = (cnt_reg == 16'(CFG_CYCLES - 1));

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    mode_next   = mode_reg;
    start_next  = 1'b0;
    unique case (state_reg)
      RPT_HELD: begin
        cnt_next = '0;
        if (por_n && !por_d_reg) begin
          state_next = RPT_WAIT;
        end
      end
      RPT_WAIT: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(SAMPLE_CYCLES - 1)) begin
          mode_next  = tp_sync;
          cnt_next   = '0;
          start_next = 1'b1;
          state_next = RPT_CONFIG;
        end
      end
      RPT_CONFIG: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cfg_done) begin
          state_next = RPT_RUN;
        end
      end
      RPT_RUN: begin
        if (!park_n || ctrl_reg[0]) begin
          state_next = RPT_PARKING;
        end
        cnt_next = '0;
      end
      RPT_PARKING: begin
        state_next = RPT_PARKED;
      end
      RPT_PARKED: begin
        if (park_n && !ctrl_reg[0]) begin
          state_next = RPT_RUN;
        end
      end
      default: state_next = RPT_HELD;
    endcase
    if (!por_n) begin
      state_next = RPT_HELD;
      cnt_next   = '0;
    end
    cfg_next  = (state_next == RPT_RUN);
    test_next = (state_next != RPT_HELD) && (state_next != RPT_WAIT) && (mode_next != '0);
    park_next = (state_next == RPT_PARKING) || (state_next == RPT_PARKED);
    fast_next = park_next && !park_n;
    if (state_next == RPT_HELD || state_next == RPT_WAIT) begin
      oe_n_next   = '1;
      tp_out_next = '0;
    end else begin
      oe_n_next   = '0;
      tp_out_next = {{(TP_WIDTH-3){1'b0}}, park_next, cfg_next, test_next};
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state_reg              <= RPT_HELD;
      cnt_reg                <= '0;
      mode_reg               <= '0;
      por_d_reg              <= 1'b0;
      O_CONFIG_START         <= 1'b0;
      O_CONFIGURED           <= 1'b0;
      O_TEST_MODE            <= 1'b0;
      O_MIRROR_PARK          <= 1'b0;
      O_MIRROR_FAST          <= 1'b0;
      O_TEST_POINT_PINS_OE_N <= '1;
      O_TEST_POINT_PINS      <= '0;
    end else begin
      state_reg              <= state_next;
      cnt_reg                <= cnt_next;
      mode_reg               <= mode_next;
      por_d_reg              <= por_n;
      O_CONFIG_START         <= start_next;
      O_CONFIGURED           <= cfg_next;
      O_TEST_MODE            <= test_next;
      O_MIRROR_PARK          <= park_next;
      O_MIRROR_FAST          <= fast_next;
      O_TEST_POINT_PINS_OE_N <= oe_n_next;
      O_TEST_POINT_PINS      <= tp_out_next;
    end
  end

  // AXI4-Lite slave
  logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0]  bresp_next, rresp_next;
  logic [31:0] rdata_next, status_word;

  assign status_word = {25'h0, state_reg, mfg_strap, O_MIRROR_PARK, O_TEST_MODE, O_CONFIGURED};

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    ctrl_next    = ctrl_reg;
    bvalid_next  = O_BVALID && !I_BREADY;
    bresp_next   = O_BRESP;
    rvalid_next  = O_RVALID && !I_RREADY;
    rresp_next   = O_RRESP;
    rdata_next   = O_RDATA;
    if (I_AWVALID && O_AWREADY) begin
      aw_hold_next = 1'b1;
      awaddr_next  = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_hold_next = 1'b1;
      wdata_next  = I_WDATA;
      wstrb_next  = I_WSTRB;
    end
    if (aw_hold_reg && w_hold_reg && !O_BVALID) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RPT_RESP_OKAY;
      if (awaddr_reg == `RPT_ADDR_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            ctrl_next[b*8 +: 8] = wdata_reg[b*8 +: 8];
          end
        end
      end else if (awaddr_reg != `RPT_ADDR_STATUS && awaddr_reg != `RPT_ADDR_STRAP) begin
        bresp_next = `RPT_RESP_SLVERR;
      end
    end
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next  = !w_hold_next && !bvalid_next;
    if (I_ARVALID && O_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next  = `RPT_RESP_OKAY;
      unique case (I_ARADDR)
        `RPT_ADDR_CTRL:   rdata_next = ctrl_reg;
        `RPT_ADDR_STATUS: rdata_next = status_word;
        `RPT_ADDR_STRAP:  rdata_next = 32'(mode_reg);
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `RPT_RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      ctrl_reg    <= `RPT_CTRL_RESET;
      O_AWREADY   <= 1'b0;
      O_WREADY    <= 1'b0;
      O_BVALID    <= 1'b0;
      O_BRESP     <= 2'b00;
      O_ARREADY   <= 1'b0;
      O_RVALID    <= 1'b0;
      O_RRESP     <= 2'b00;
      O_RDATA     <= 32'h0000_0000;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      ctrl_reg    <= ctrl_next;
      O_AWREADY   <= awready_next;
      O_WREADY    <= wready_next;
      O_BVALID    <= bvalid_next;
      O_BRESP     <= bresp_next;
      O_ARREADY   <= arready_next;
      O_RVALID    <= rvalid_next;
      O_RRESP     <= rresp_next;
      O_RDATA     <= rdata_next;
    end
  end

  // Assertions
  property p_held_quiet;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_HELD) |=> !O_CONFIGURED && !O_MIRROR_PARK && !O_CONFIG_START;
  endproperty
  a_held_quiet: assert property (p_held_quiet) else $error("output active while held");
  property p_reset_return;
    @(posedge I_MCLK) disable iff (I_RESET)
    (!por_n && state_reg != RPT_HELD) |=> (state_reg == RPT_HELD);
  endproperty
  a_reset_return: assert property (p_reset_return) else $error("reset low did not return to held");
  property p_rise_starts;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_HELD && por_n && !por_d_reg) |=> (state_reg == RPT_WAIT);
  endproperty
  a_rise_starts: assert property (p_rise_starts) else $error("release did not start");
  property p_tristate;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_HELD) |=> (O_TEST_POINT_PINS_OE_N == '1);
  endproperty
  a_tristate: assert property (p_tristate) else $error("test points driven in reset");
  // Checker-side count of cycles spent waiting for the sample point
  logic [15:0] wait_len_reg, wait_len_next;
  always_comb begin
    wait_len_next = (state_reg == RPT_WAIT) ? wait_len_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      wait_len_reg <= 16'h0000;
    end else begin
      wait_len_reg <= wait_len_next;
    end
  end
  property p_sample_time;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_CONFIG && $past(state_reg) == RPT_WAIT) |-> (wait_len_reg == 16'(SAMPLE_CYCLES));
  endproperty
  a_sample_time: assert property (p_sample_time) else $error("sample not after 1.5 us");
  property p_drive_after;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_CONFIG && por_n) |=> (O_TEST_POINT_PINS_OE_N == '0);
  endproperty
  a_drive_after: assert property (p_drive_after) else $error("test points not driven");
  property p_mode_sel;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_RUN) |-> (O_TEST_MODE == (mode_reg != '0));
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("test mode mismatch");
  property p_fast_park;
    @(posedge I_MCLK) disable iff (I_RESET)
    (state_reg == RPT_RUN && !park_n && por_n) |=> (O_MIRROR_PARK && O_MIRROR_FAST);
  endproperty
  a_fast_park: assert property (p_fast_park) else $error("park not raised");
  property p_sync_lag;
    @(posedge I_MCLK) disable iff (I_RESET)
    $rose(por_n) |-> $past(I_POWER_ON_RESET_N, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("reset sync lag wrong");
  c_config: cover property (@(posedge I_MCLK) disable iff (I_RESET) $rose(O_CONFIGURED));
  c_test:   cover property (@(posedge I_MCLK) disable iff (I_RESET) $rose(O_TEST_MODE));
  c_park:   cover property (@(posedge I_MCLK) disable iff (I_RESET) $rose(O_MIRROR_FAST));
endmodule

// file: verif/rpt_power_partner.sv
module rpt_power_partner (
  // Clock and control from the bench
  input  wire logic       i_clk,
  input  wire logic       i_supplies_ok,
  input  wire logic       i_park_req,
  input  wire logic [7:0] i_pullup,
  // Test point pins driven by the controller
  input  wire logic [7:0] i_tp_out,
  input  wire logic [7:0] i_tp_oe_n,
  // Pins into the controller
  output logic            o_power_on_reset_n,
  output logic            o_fast_park_n,
  output logic            o_manufacturing_test_strap,
  output logic            o_test_port_reset_n,
  output logic [7:0]      o_tp_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic reset_n_reg = 1'b0;
  logic park_n_reg  = 1'b1;
  // Release only once supplies are reported stable
  always @(posedge i_clk) begin
    reset_n_reg <= i_supplies_ok;
    park_n_reg  <= ~i_park_req;
  end
  assign o_power_on_reset_n         = reset_n_reg;
  assign o_fast_park_n              = park_n_reg;
  assign o_manufacturing_test_strap = 1'b0;
  assign o_test_port_reset_n        = 1'b0;
  // Released pin falls to its pulldown unless a board pullup is fitted
  for (genvar i = 0; i < 8; i++) begin : g_wire
    assign o_tp_level[i] = i_tp_oe_n[i] ? i_pullup[i] : i_tp_out[i];
  end
endmodule

// file: verif/reset_park_test_strap_control_test.sv
module reset_park_test_strap_control_test;
  import rpt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b0, preq = 1'b0;
  logic [7:0] pu = 8'h00;
  logic por_n, park_n, mfg, tprst_n, start, cfgd, tmode, mpark, mfast;
  logic [7:0] tp_lvl, tp_out, tp_oe_n;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rd;
  int err_count = 0, checks = 0, cyc = 0, n;
  always #20 clk = ~clk;
  rpt_power_partner partner (.i_clk(clk), .i_supplies_ok(sup), .i_park_req(preq), .i_pullup(pu),
    .i_tp_out(tp_out), .i_tp_oe_n(tp_oe_n), .o_power_on_reset_n(por_n), .o_fast_park_n(park_n),
    .o_manufacturing_test_strap(mfg), .o_test_port_reset_n(tprst_n), .o_tp_level(tp_lvl));
  rpt_top dut (.I_MCLK(clk), .I_RESET(rst), .I_POWER_ON_RESET_N(por_n), .I_FAST_PARK_N(park_n),
    .I_MANUFACTURING_TEST_STRAP(mfg), .I_TEST_PORT_RESET_N(tprst_n), .I_TEST_POINT_PINS(tp_lvl),
    .O_TEST_POINT_PINS(tp_out), .O_TEST_POINT_PINS_OE_N(tp_oe_n), .O_CONFIG_START(start),
    .O_CONFIGURED(cfgd), .O_TEST_MODE(tmode), .O_MIRROR_PARK(mpark), .O_MIRROR_FAST(mfast),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Pin held low: nothing active, test points released to their pull levels
  task automatic held_checks();
    chk({27'h0, start, cfgd, tmode, mpark, mfast}, 32'h0);
    chk({24'h0, tp_oe_n}, 32'h0000_00FF);
    chk({24'h0, tp_lvl}, {24'h0, pu});
  endtask
  // Release the power pin and time sampling and self-configuration
  task automatic power_up(input logic [7:0] straps);
    pu <= straps;
    repeat (4) @(posedge clk);
    held_checks();
    sup <= 1'b1;
    do @(posedge clk); while (por_n !== 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (start !== 1'b1) chk({24'h0, tp_oe_n}, 32'h0000_00FF);
    end while (start !== 1'b1 && n < 60);
    chk(n >= 38 && n <= 42, 1);
    chk({24'h0, tp_oe_n}, 32'h0);
    chk(tmode, straps != 8'h00);
    pu <= 8'h00;
    n = 0;
    do begin @(posedge clk); n++; end while (cfgd !== 1'b1 && n < 30);
    chk(n >= 14 && n <= 19, 1);
    chk(tmode, straps != 8'h00);
    chk({24'h0, tp_lvl}, {29'h0, 1'b0, 1'b1, straps != 8'h00});
    axi_rd(12'h008, rd, resp);
    chk(rd, {24'h0, straps});
    axi_rd(12'h004, rd, resp);
    chk(rd[3:0], {2'b00, straps != 8'h00, 1'b1});
  endtask
  task automatic power_down();
    sup <= 1'b0;
    repeat (6) @(posedge clk);
    held_checks();
  endtask
  task automatic fast_park();
    preq <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (mpark !== 1'b1 && n < 20);
    chk(n >= 4 && n <= 7, 1);
    chk({cfgd, mfast}, 2'b01);
    preq <= 1'b0;
    repeat (8) @(posedge clk);
    chk({mpark, cfgd}, 2'b01);
  endtask
  task automatic soft_park_and_bus();
    axi_wr(12'h000, 32'h0000_0001, resp);
    chk(resp, 2'b00);
    repeat (3) @(posedge clk);
    chk({mpark, mfast}, 2'b10);
    axi_rd(12'h004, rd, resp);
    chk(rd[2], 1'b1);
    axi_wr(12'h004, 32'h0000_0000, resp);
    chk(resp, 2'b00);
    axi_wr(12'h000, 32'h0000_0000, resp);
    axi_rd(12'h000, rd, resp);
    chk(rd, 32'h0);
    axi_rd(12'h010, rd, resp);
    chk({rd, resp}, {32'h0, 2'b10});
    axi_wr(12'h010, 32'h0000_00A5, resp);
    chk(resp, 2'b10);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    power_up(8'h00);
    fast_park();
    soft_park_and_bus();
    power_down();
    power_up(8'h24);
    power_down();
    power_up(8'h81);
    tally_and_finish();
  end
endmodule
